// ---- design/pm_pkg.sv ----
/*
 * constants, types and register map of the suspend/resume power state
 * controller; assumes a 40 mhz clock and an avalon-mm register bus.
 */
package pm_pkg;
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_WAKE_EN = 5'h04;
    localparam logic [4:0] OFF_WAKE_STS = 5'h08;
    localparam logic [4:0] OFF_IDLE = 5'h0c;
    localparam logic [4:0] OFF_STATUS = 5'h10;

    localparam int CTRL_TYPE_LSB = 0;
    localparam int CTRL_EN_BIT = 2;
    localparam int CTRL_DEPTH_LSB = 3;
    localparam int COVER_POL_BIT = 10;
    localparam int SMI_STS_BIT = 10;
    localparam int IDLE_RES_LSB = 8;
    localparam int IDLE_RUN_BIT = 10;
    localparam int STAT_PINS_LSB = 6;

    localparam logic [1:0] RST_TYPE = 2'h0;
    localparam logic [9:0] RST_WAKE_EN = 10'h000;
    localparam logic [7:0] RST_IDLE_RELOAD = 8'hff;

    localparam logic [1:0] TYPE_POS = 2'h0;
    localparam logic [1:0] TYPE_STR = 2'h1;
    localparam logic [1:0] TYPE_STD = 2'h2;
    localparam logic [2:0] DEPTH_POS = 3'h3;

    localparam int W_BUTTON = 0;
    localparam int W_COVER = 1;
    localparam int W_GENERAL = 2;
    localparam int W_EXTREQ = 3;
    localparam int W_TARGET = 4;
    localparam int W_MODEM = 5;
    localparam int W_RTC = 6;
    localparam int W_IDLE = 7;
    localparam int W_IRQ = 8;
    localparam int W_USB = 9;
    localparam int NUM_WAKE = 10;
    localparam logic [15:0] IRQ_WAKE_MASK = 16'hfefa;

    localparam int CLK_PERIOD_NS = 25;
    localparam int SLOW_PERIOD_NS = 32000;
    localparam int SLOW_DIV = (SLOW_PERIOD_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int DEBOUNCE_MS = 16;
    localparam int DEBOUNCE_TICKS = (DEBOUNCE_MS * 1000000
        + SLOW_PERIOD_NS - 1) / SLOW_PERIOD_NS;
    localparam int MIN_WIDTH_US = 64;
    localparam int MIN_WIDTH_TICKS = (MIN_WIDTH_US * 1000
        + SLOW_PERIOD_NS - 1) / SLOW_PERIOD_NS;
    localparam int IDLE_RES0_MS = 1000;
    localparam int IDLE_RES1_MS = 8000;
    localparam int IDLE_RES2_MS = 32000;
    localparam int IDLE_RES3_MS = 120000;
    localparam int IDLE_RES0_TICKS = IDLE_RES0_MS * 1000 / 32;
    localparam int IDLE_RES1_TICKS = IDLE_RES1_MS * 1000 / 32;
    localparam int IDLE_RES2_TICKS = IDLE_RES2_MS * 1000 / 32;
    localparam int IDLE_RES3_TICKS = IDLE_RES3_MS * 1000 / 32;

    typedef enum logic [2:0] {
        ST_MECHANICAL_POWER_OFF, ST_RELEASE, ST_ON, ST_ENTER, ST_SLEEP, ST_EXIT
    } pm_state_e;

    typedef struct packed {
        logic reset_n;
        logic host_n;
        logic periph_n;
        logic a_n;
        logic b_n;
        logic c_n;
    } pm_pins_s;
endpackage

// ---- design/suspend_resume_power_state_control.sv ----
/*
 * suspend/resume sequencer: power-state outputs, wake qualification,
 * global idle timer and avalon-mm register slave.
 * assumes all inputs synchronous to clk and a suspend-well power-good.
 */
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module suspend_resume_power_state_control #(
    parameter int SLOW_DIV = pm_pkg::SLOW_DIV,
    parameter int DEBOUNCE_TICKS = pm_pkg::DEBOUNCE_TICKS,
    parameter int IDLE_UNIT0 = pm_pkg::IDLE_RES0_TICKS,
    parameter int IDLE_UNIT1 = pm_pkg::IDLE_RES1_TICKS,
    parameter int IDLE_UNIT2 = pm_pkg::IDLE_RES2_TICKS,
    parameter int IDLE_UNIT3 = pm_pkg::IDLE_RES3_TICKS
) (
    input wire logic clk, // 40 mhz
    input wire logic rst_n, // async reset
    input wire logic [4:0] address, // byte address
    input wire logic read, // bus read
    input wire logic write, // bus write
    input wire logic [3:0] byteenable, // write lanes
    input wire logic [31:0] writedata, // write data
    output logic [31:0] readdata, // read data
    output logic waitrequest, // bus stall
    input wire logic suspend_power_ok, // suspend well powered
    input wire logic power_button_n, // button, low active
    input wire logic cover_switch_input, // cover switch
    input wire logic general_wake_input, // general input one
    input wire logic external_mgmt_request_n, // external request
    input wire logic smbus_wake, // smbus match or alert
    input wire logic modem_wake_n, // ring, low active
    input wire logic rtc_alarm, // internal rtc alarm
    input wire logic [15:0] irq_wake, // interrupt lines
    input wire logic usb_resume, // usb resume signalling
    input wire logic system_activity, // idle timer reload pulse
    output logic suspend_well_reset_n, // suspend well reset
    output logic host_suspend_status_n, // to host bridge
    output logic peripheral_suspend_status_n, // to peripherals
    output logic plane_a_off_n, // plane a control
    output logic plane_b_off_n, // plane b control
    output logic plane_c_off_n, // plane c control
    output logic slow_suspend_clock, // refresh clock
    output logic system_mgmt_interrupt_n, // idle expiry
    output logic full_system_reset_n // resume reset
);
    typedef struct packed {
        pm_pkg::pm_state_e state;
        logic [2:0] depth;
        logic [2:0] target;
        logic [1:0] stype;
        logic pend;
        logic [11:0] div;
        logic tick;
        logic [pm_pkg::NUM_WAKE-1:0] s1;
        logic [pm_pkg::NUM_WAKE-1:0] s2;
        logic [1:0][9:0] deb;
        logic [3:0][1:0] wid;
        logic [pm_pkg::NUM_WAKE-1:0] wake_en;
        logic cover_pol;
        logic [pm_pkg::NUM_WAKE-1:0] sts;
        logic smi_sts;
        logic [7:0] idle_reload;
        logic [1:0] idle_res;
        logic idle_run;
        logic [7:0] idle_cnt;
        logic [21:0] idle_pre;
        logic idle_exp;
        pm_pkg::pm_pins_s pins;
        logic sck;
        logic rst_sys_n;
        logic waitreq;
        logic [31:0] rdata;
    } st_s;

    st_s st;
    st_s next_st;
    logic [pm_pkg::NUM_WAKE-1:0] raw;
    logic [pm_pkg::NUM_WAKE-1:0] qual;
    logic [pm_pkg::NUM_WAKE-1:0] allow;
    logic [pm_pkg::NUM_WAKE-1:0] ev;
    logic [9:0] wclr;
    logic [21:0] unit;
    logic [31:0] lanes;
    logic [31:0] bmask;

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [2:0] type_depth(input logic [1:0] t);
        type_depth = (t == pm_pkg::TYPE_POS) ? 3'h3 :
            (t == pm_pkg::TYPE_STR) ? 3'h4 : 3'h5;
    endfunction

    function automatic pm_pkg::pm_pins_s pins_of(
        input pm_pkg::pm_state_e s, input logic [2:0] d);
        logic on;
        on = (s != pm_pkg::ST_MECHANICAL_POWER_OFF);
        pins_of.reset_n = on;
        pins_of.host_n = on && d < 3'h1;
        pins_of.periph_n = on && d < 3'h2;
        pins_of.a_n = on && d < 3'h3;
        pins_of.b_n = on && d < 3'h4;
        pins_of.c_n = on && d < 3'h5;
    endfunction

    // raw wake levels, active high; idle comes from the timer itself
    always_comb begin
        raw = '0;
        raw[pm_pkg::W_BUTTON] = !power_button_n;
        raw[pm_pkg::W_COVER] = (cover_switch_input == st.cover_pol);
        raw[pm_pkg::W_GENERAL] = general_wake_input;
        raw[pm_pkg::W_EXTREQ] = !external_mgmt_request_n;
        raw[pm_pkg::W_TARGET] = smbus_wake;
        raw[pm_pkg::W_MODEM] = !modem_wake_n;
        raw[pm_pkg::W_RTC] = rtc_alarm;
        raw[pm_pkg::W_IRQ] = |(irq_wake & pm_pkg::IRQ_WAKE_MASK);
        raw[pm_pkg::W_USB] = usb_resume;
    end

    always_comb begin
        qual = st.s2;
        for (int i = 0; i < 2; i++) begin
            qual[i] = st.deb[i] > 10'(DEBOUNCE_TICKS);
        end
        for (int i = 0; i < 4; i++) begin
            qual[i < 2 ? i + 2 : i + 6] =
                st.wid[i] >= 2'(pm_pkg::MIN_WIDTH_TICKS);
        end
        qual[pm_pkg::W_IDLE] = st.idle_exp;
        allow = '1;
        if (st.target != pm_pkg::DEPTH_POS) begin
            allow[pm_pkg::W_IRQ] = 1'b0;
            allow[pm_pkg::W_USB] = 1'b0;
        end
        ev = qual & st.wake_en & allow;
    end

    always_comb begin
        unique case (st.idle_res)
            2'h0: unit = 22'(IDLE_UNIT0);
            2'h1: unit = 22'(IDLE_UNIT1);
            2'h2: unit = 22'(IDLE_UNIT2);
            2'h3: unit = 22'(IDLE_UNIT3);
        endcase
    end

    assign lanes = lane_mask(byteenable);
    assign bmask = lanes & writedata;

    always_comb begin
        next_st = st;
        wclr = '0;
        next_st.tick = 1'b0;
        next_st.idle_exp = 1'b0;
        next_st.div = st.div + 12'h001;
        if (st.div == 12'(SLOW_DIV - 1)) begin
            next_st.div = '0;
            next_st.tick = 1'b1;
        end
        // bus: one wait cycle, effect at the edge waitrequest is low
        next_st.waitreq = !((read || write) && st.waitreq);
        if (read && st.waitreq) begin
            unique case (address)
                pm_pkg::OFF_CTRL: next_st.rdata = 32'({st.depth,
                    st.pend || st.state == pm_pkg::ST_ENTER, st.stype});
                pm_pkg::OFF_WAKE_EN:
                    next_st.rdata = 32'({st.cover_pol, st.wake_en});
                pm_pkg::OFF_WAKE_STS:
                    next_st.rdata = 32'({st.smi_sts, st.sts});
                pm_pkg::OFF_IDLE: next_st.rdata = 32'({st.idle_run,
                    st.idle_res, st.idle_reload});
                pm_pkg::OFF_STATUS: next_st.rdata = 32'({st.pins,
                    st.depth, 3'(st.state)});
                default: next_st.rdata = '0;
            endcase
        end
        if (write && !st.waitreq) begin
            unique case (address)
                pm_pkg::OFF_CTRL: if (byteenable[0]) begin
                    next_st.stype = writedata[1:0];
                    if (writedata[pm_pkg::CTRL_EN_BIT]) begin
                        next_st.pend = 1'b1;
                    end
                end
                pm_pkg::OFF_WAKE_EN: begin
                    next_st.wake_en = (st.wake_en & ~lanes[9:0]) | bmask[9:0];
                    if (byteenable[1]) begin
                        next_st.cover_pol = writedata[pm_pkg::COVER_POL_BIT];
                    end
                end
                pm_pkg::OFF_WAKE_STS: begin
                    wclr = bmask[9:0];
                    if (bmask[pm_pkg::SMI_STS_BIT]) begin
                        next_st.smi_sts = 1'b0;
                    end
                end
                pm_pkg::OFF_IDLE: begin
                    if (byteenable[0]) begin
                        next_st.idle_reload = writedata[7:0];
                    end
                    if (byteenable[1]) begin
                        next_st.idle_res = writedata[9:8];
                        next_st.idle_run = writedata[pm_pkg::IDLE_RUN_BIT];
                    end
                    next_st.idle_cnt = next_st.idle_reload;
                    next_st.idle_pre = '0;
                end
                default: ;
            endcase
        end
        next_st.sts = st.sts & ~wclr;
        // wake inputs are only looked at once per slow tick
        if (st.tick) begin
            next_st.s1 = raw;
            next_st.s2 = st.s1;
            for (int i = 0; i < 2; i++) begin
                if (!st.s2[i]) begin
                    next_st.deb[i] = '0;
                end else if (st.deb[i] <= 10'(DEBOUNCE_TICKS)) begin
                    next_st.deb[i] = st.deb[i] + 10'h001;
                end
            end
            for (int i = 0; i < 4; i++) begin
                if (!st.s2[i < 2 ? i + 2 : i + 6]) begin
                    next_st.wid[i] = '0;
                end else if (st.wid[i] != 2'h3) begin
                    next_st.wid[i] = st.wid[i] + 2'h1;
                end
            end
        end
        // idle timer keeps counting in sleep so it can wake the system
        if (system_activity && st.state == pm_pkg::ST_ON) begin
            next_st.idle_cnt = st.idle_reload;
            next_st.idle_pre = '0;
        end else if (st.tick && st.idle_run && st.idle_cnt != 8'h00) begin
            next_st.idle_pre = st.idle_pre + 22'h000001;
            if (st.idle_pre >= unit - 22'h000001) begin
                next_st.idle_pre = '0;
                next_st.idle_cnt = st.idle_cnt - 8'h01;
                next_st.idle_exp = (st.idle_cnt == 8'h01);
            end
        end
        if (st.idle_exp && st.state == pm_pkg::ST_ON) begin
            next_st.smi_sts = 1'b1;
        end
        unique case (st.state)
            pm_pkg::ST_MECHANICAL_POWER_OFF: if (st.tick) begin
                next_st.state = pm_pkg::ST_RELEASE;
                next_st.depth = 3'h5;
            end
            pm_pkg::ST_RELEASE: if (st.tick) begin
                next_st.state = pm_pkg::ST_ON;
                next_st.depth = '0;
            end
            pm_pkg::ST_ON: if (st.tick && st.pend) begin
                next_st.state = pm_pkg::ST_ENTER;
                next_st.target = type_depth(st.stype);
                next_st.pend = 1'b0;
            end
            pm_pkg::ST_ENTER: if (st.tick) begin
                if (st.depth < st.target) begin
                    next_st.depth = st.depth + 3'h1;
                end else begin
                    next_st.state = pm_pkg::ST_SLEEP;
                end
            end
            pm_pkg::ST_SLEEP: if (|ev) begin
                next_st.sts = next_st.sts | ev;
                next_st.state = pm_pkg::ST_EXIT;
            end
            pm_pkg::ST_EXIT: if (st.tick) begin
                if (st.depth != 3'h0) begin
                    next_st.depth = st.depth - 3'h1;
                end else begin
                    next_st.state = pm_pkg::ST_ON;
                end
            end
        endcase
        if (!suspend_power_ok) begin
            next_st.state = pm_pkg::ST_MECHANICAL_POWER_OFF;
            next_st.depth = 3'h5;
        end
        next_st.pins = pins_of(next_st.state, next_st.depth);
        next_st.sck = next_st.div < 12'(SLOW_DIV / 2) &&
            next_st.state == pm_pkg::ST_SLEEP &&
            st.target != 3'h5;
        next_st.rst_sys_n = !(next_st.state == pm_pkg::ST_EXIT &&
            st.target > pm_pkg::DEPTH_POS);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{state: pm_pkg::ST_MECHANICAL_POWER_OFF, depth: 3'h5, target: 3'h3,
                stype: pm_pkg::RST_TYPE, wake_en: pm_pkg::RST_WAKE_EN,
                idle_reload: pm_pkg::RST_IDLE_RELOAD, rst_sys_n: 1'b1,
                waitreq: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign readdata = st.rdata;
    assign waitrequest = st.waitreq;
    assign suspend_well_reset_n = st.pins.reset_n;
    assign host_suspend_status_n = st.pins.host_n;
    assign peripheral_suspend_status_n = st.pins.periph_n;
    assign plane_a_off_n = st.pins.a_n;
    assign plane_b_off_n = st.pins.b_n;
    assign plane_c_off_n = st.pins.c_n;
    assign slow_suspend_clock = st.sck;
    assign system_mgmt_interrupt_n = !st.smi_sts;
    assign full_system_reset_n = st.rst_sys_n;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_mechanical_power_off_outputs: assert property (!suspend_power_ok |=>
        !suspend_well_reset_n && !peripheral_suspend_status_n &&
        !plane_a_off_n && !plane_b_off_n && !plane_c_off_n)
        else $error("outputs not low without suspend power");
    chk_on_levels: assert property (st.state == pm_pkg::ST_ON |->
        suspend_well_reset_n && peripheral_suspend_status_n &&
        plane_a_off_n && plane_b_off_n && plane_c_off_n)
        else $error("full on levels wrong");
    chk_pos_levels: assert property (st.state == pm_pkg::ST_SLEEP &&
        st.target == 3'h3 |-> !host_suspend_status_n && !plane_a_off_n &&
        !peripheral_suspend_status_n && plane_b_off_n && plane_c_off_n)
        else $error("pos levels wrong");
    chk_str_levels: assert property (st.state == pm_pkg::ST_SLEEP &&
        st.target == 3'h4 |-> !plane_a_off_n && !plane_b_off_n &&
        !host_suspend_status_n && plane_c_off_n)
        else $error("str levels wrong");
    chk_std_levels: assert property (st.state == pm_pkg::ST_SLEEP &&
        st.target == 3'h5 |-> suspend_well_reset_n && !plane_c_off_n &&
        !plane_b_off_n && !peripheral_suspend_status_n)
        else $error("std levels wrong");
    // loss of suspend power drops every pin at once, so it is left out
    chk_entry_order: assert property ($fell(plane_a_off_n) &&
        suspend_well_reset_n |->
        !peripheral_suspend_status_n && $past(!peripheral_suspend_status_n))
        else $error("plane a fell before peripheral status");
    chk_deep_no_irq: assert property (st.state == pm_pkg::ST_SLEEP &&
        st.target != 3'h3 && (qual & st.wake_en & ~(10'h300)) == '0
        |=> st.state != pm_pkg::ST_EXIT)
        else $error("interrupt woke from deep sleep");
    chk_wake_status: assert property (st.state == pm_pkg::ST_SLEEP &&
        |ev |=> st.state == pm_pkg::ST_EXIT && (st.sts & $past(ev)) != '0)
        else $error("wake event lost");
    chk_deep_reset: assert property ($rose(st.state == pm_pkg::ST_EXIT) &&
        st.target > 3'h3 |-> !full_system_reset_n)
        else $error("no system reset on deep resume");
    chk_clock_on: assert property (st.state == pm_pkg::ST_ON |->
        !slow_suspend_clock) else $error("slow clock running when on");
    chk_hold_request: assert property (st.state ==
        pm_pkg::ST_EXIT |=> st.state != pm_pkg::ST_ENTER)
        else $error("suspend started during resume");
    chk_bus_answer: assert property ((read || write) && waitrequest |=>
        !waitrequest) else $error("bus answer late");
    cov_pos_sleep: cover property (st.state == pm_pkg::ST_SLEEP &&
        st.target == 3'h3);
    cov_std_resume: cover property (st.state == pm_pkg::ST_EXIT &&
        st.target == 3'h5);
    cov_idle_smi: cover property ($fell(system_mgmt_interrupt_n));
endmodule

// ---- bench/wake_partner.sv ----
/*
 * wake sources and host bridge seen from the power sequencer.
 * assumes the bench calls hold and poke from its own processes.
 */
`timescale 1ns/1ps
module wake_partner (
    input wire logic clk, // system clock
    input wire logic host_suspend_status_n, // from the sequencer
    output logic [9:0] act, // active sources, sequencer bit order
    output logic system_activity // idle reload pulse
);
    logic slow_refresh;
    initial begin
        act = 10'h000;
        system_activity = 1'b0;
    end
    // host clock stops, so refresh must move to the slow clock
    always_comb slow_refresh = ~host_suspend_status_n;
    // width is chosen by the caller: short for refusal, long to wake
    task automatic hold(input int src, input int cyc);
        @(posedge clk) act[src] <= 1'b1;
        repeat (cyc) @(posedge clk);
        act[src] <= 1'b0;
    endtask
    task automatic poke();
        @(posedge clk) system_activity <= 1'b1;
        @(posedge clk) system_activity <= 1'b0;
    endtask
endmodule

// ---- bench/tb_suspend_resume_power_state_control.sv ----
/*
 * bench for the suspend/resume sequencer: avalon-mm master tasks,
 * suspend and wake for each type, idle timer, loss of suspend power.
 * assumes the partner model in wake_partner.sv.
 */
`timescale 1ns/1ps
module tb_suspend_resume_power_state_control;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] be = 4'hf;
    logic power_ok = 1'b1;
    logic [31:0] readdata, rd;
    logic waitrequest, well_n, host_n, periph_n, a_n, b_n, c_n;
    logic sclk, smi_n, sys_rst_n, activity, saw_reset;
    logic [9:0] act;
    logic [5:0] pins;
    int err_total = 0;
    int n_tests = 0;
    int cycles = 0;
    int toggles = 0;
    assign pins = {well_n, host_n, periph_n, a_n, b_n, c_n};

    // only the first idle resolution is run, the others keep defaults
    suspend_resume_power_state_control #(.SLOW_DIV(8),
        .DEBOUNCE_TICKS(4), .IDLE_UNIT0(2)) dut (
        .clk(clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .byteenable(be), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .suspend_power_ok(power_ok), .power_button_n(~act[0]),
        .cover_switch_input(act[1]), .general_wake_input(act[2]),
        .external_mgmt_request_n(~act[3]), .smbus_wake(act[4]),
        .modem_wake_n(~act[5]), .rtc_alarm(act[6]),
        .irq_wake({12'h000, act[8], 3'h0}), .usb_resume(act[9]),
        .system_activity(activity), .suspend_well_reset_n(well_n),
        .host_suspend_status_n(host_n),
        .peripheral_suspend_status_n(periph_n), .plane_a_off_n(a_n),
        .plane_b_off_n(b_n), .plane_c_off_n(c_n),
        .slow_suspend_clock(sclk), .system_mgmt_interrupt_n(smi_n),
        .full_system_reset_n(sys_rst_n));
    wake_partner wk (.clk(clk), .host_suspend_status_n(host_n),
        .act(act), .system_activity(activity));

    always #12.5 clk = ~clk;
    always @(sclk) toggles = toggles + 1;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_total++;
            tally_and_finish();
        end
    end
    // status and planes may only fall from host toward plane c
    always @(negedge clk) begin
        if (well_n === 1'b1 && (pins[4:0] & (pins[4:0] + 5'h01)) !== 5'h00) begin
            err_total++;
            $display("MISMATCH order expected prefix seen %b", pins);
        end
        if (sys_rst_n === 1'b0) saw_reset = 1'b1;
    end

    task automatic chk(input string what, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a,
        input logic [31:0] d);
        @(posedge clk);
        read <= ~wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wait_state(input logic [2:0] s);
        int n;
        n = 0;
        do begin
            bus(1'b0, pm_pkg::OFF_STATUS, 32'h0);
            n++;
        end while (rd[2:0] !== s && n < 200);
    endtask
    task automatic one_type(input int t);
        int src;
        src = t == 0 ? pm_pkg::W_IRQ :
            t == 1 ? pm_pkg::W_BUTTON : pm_pkg::W_GENERAL;
        // cover polarity high and interrupt wake enabled in every type
        bus(1'b1, pm_pkg::OFF_WAKE_EN, 32'h500 | (32'h1 << src));
        bus(1'b1, pm_pkg::OFF_CTRL, 32'(t + 4));
        wait_state(3'h4);
        chk("sleep", t == 0 ? 32'h23 : t == 1 ? 32'h21 : 32'h20, 32'(pins));
        toggles = 0;
        saw_reset = 1'b0;
        fork
            wk.hold(pm_pkg::W_MODEM, 48);
            if (t != 0) wk.hold(pm_pkg::W_IRQ, 48);
            wk.hold(src, t == 1 ? 16 : 4);
        join
        repeat (24) @(posedge clk);
        bus(1'b0, pm_pkg::OFF_STATUS, 32'h0);
        chk("no wake", 32'h4, 32'(rd[2:0]));
        chk("slow clock", 32'(t != 2), 32'(toggles != 0));
        wk.hold(src, 80);
        wait_state(3'h2);
        chk("full on", 32'h3f, 32'(pins));
        bus(1'b0, pm_pkg::OFF_WAKE_STS, 32'h0);
        chk("wake flag", 32'h1, (rd >> src) & 32'h1);
        bus(1'b1, pm_pkg::OFF_WAKE_STS, 32'h7ff);
        chk("resume reset", 32'(t != 0), 32'(saw_reset));
        $display("suspend type %0d done", t);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        int n;
        repeat (16) @(posedge clk);
        chk("reset pins", 32'h0, 32'(pins));
        rst_n <= 1'b1;
        wait_state(3'h2);
        chk("on pins", 32'h3f, 32'(pins));
        bus(1'b0, pm_pkg::OFF_IDLE, 32'h0);
        chk("idle reload", 32'hff, rd & 32'hff);
        // only lane 1 enabled: the reload byte must survive the write
        be <= 4'h2;
        bus(1'b1, pm_pkg::OFF_IDLE, 32'h133);
        be <= 4'hf;
        bus(1'b0, pm_pkg::OFF_IDLE, 32'h0);
        chk("byte lanes", 32'h1ff, rd);
        bus(1'b0, 5'h14, 32'h0);
        chk("unmapped", 32'h0, rd);
        for (int t = 0; t < 3; t++) one_type(t);
        bus(1'b1, pm_pkg::OFF_IDLE, 32'h403);
        wk.poke();
        for (n = 0; n < 400 && smi_n !== 1'b0; n++) @(negedge clk);
        chk("idle smi", 32'h0, 32'(smi_n));
        $display("idle timer done");
        power_ok <= 1'b0;
        for (n = 0; n < 100 && well_n !== 1'b0; n++) @(negedge clk);
        repeat (8) @(negedge clk);
        chk("power loss", 32'h0, 32'(pins));
        $display("power loss done");
        tally_and_finish();
    end
endmodule
